/* File: pmbt_pkg.sv */
// pmbt_pkg: shared constants and types of the parallel master bus sequencer.
// assumes every user of it imports the whole package or names items by scope.
package pmbt_pkg;

    // widths of the software side, of the pins and of the phase timer
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int ADDR_W     = 16;
    localparam int PIN_ADDR_W = 14;
    localparam int TIMER_W    = 5;

    // address/data multiplex settings
    localparam logic [1:0] MUX_DEMUX  = 2'h0;
    localparam logic [1:0] MUX_PART   = 2'h1;
    localparam logic [1:0] MUX_FULL8  = 2'h2;
    localparam logic [1:0] MUX_FULL16 = 2'h3;

    // strobe schemes
    localparam logic SCHEME_DIR_ENABLE = 1'b0;
    localparam logic SCHEME_RD_WR      = 1'b1;

    // address bit positions doubling as chip selects
    localparam int CS_TWO_BIT = 15;
    localparam int CS_ONE_BIT = 14;

    // timing: an address latch phase is this many clocks plus the setup phase
    localparam int         ALAT_BASE_CYC   = 2;
    localparam int         WAIT_ADD_CYC    = 1;
    localparam int         FORCED_WAIT_CYC = 1;
    localparam logic [3:0] STROBE_WAIT_OFF = 4'h0;

    // reset values
    localparam logic [DATA_W-1:0] BUS_DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST     = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALAT_LO,
        ST_ALAT_HI,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } pmbt_state_t;

endpackage

/* File: pmbt_phase_timer.sv */
// pmbt_phase_timer: down counter timing one phase of a bus cycle.
// assumes load values are never zero; expire marks the phase's final clock.
`timescale 1ns/1ps

module pmbt_phase_timer #(
    parameter int W = pmbt_pkg::TIMER_W
) (
    input  logic         core_clk,
    input  logic         rst_n,
    input  logic         load,
    input  logic [W-1:0] load_val,
    output logic         expire
);
    import pmbt_pkg::*;

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // a width below two cannot hold the shortest address phase
    if (W < 2) begin : g_w_check
        $error("pmbt_phase_timer: W too small");
    end

    // reload on a phase change, otherwise count down and rest at one
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_val;
        end else if (cnt_r > W'(1)) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= W'(1);
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expire = (cnt_r == W'(1));

endmodule

/* File: pmbt_core.sv */
// pmbt_core: master-side cycle sequencer of an 8/16-bit parallel port.
// assumes config inputs sit on core_clk and stay stable while busy; pin data is synchronised.
`timescale 1ns/1ps

module pmbt_core (
    input  logic                          core_clk,
    input  logic                          rst_n,
    // software side of the data and address registers
    input  logic                          sw_read_req,
    input  logic                          sw_write_req,
    input  logic [pmbt_pkg::DATA_W-1:0]   sw_write_data,
    input  logic [pmbt_pkg::ADDR_W-1:0]   bus_address_register,
    output logic [pmbt_pkg::DATA_W-1:0]   bus_data_register,
    output logic                          busy,
    output logic                          port_event_flag,
    input  logic                          port_event_clear,
    // configuration
    input  logic [1:0]                    addr_data_mux_select,
    input  logic [1:0]                    setup_wait_count,
    input  logic [3:0]                    strobe_wait_count,
    input  logic [1:0]                    hold_wait_count,
    input  logic                          strobe_scheme,
    input  logic                          data_16bit,
    input  logic                          cs_one_enable,
    input  logic                          cs_two_enable,
    // pins
    output logic                          chip_select_one,
    output logic                          chip_select_two,
    output logic [pmbt_pkg::PIN_ADDR_W-1:0] port_address_lines,
    output logic [pmbt_pkg::DATA_W-1:0]   port_data_out,
    output logic [pmbt_pkg::DATA_W-1:0]   port_data_oe,
    input  logic [pmbt_pkg::DATA_W-1:0]   port_data_in,
    output logic                          addr_latch_low_strobe,
    output logic                          addr_latch_high_strobe,
    output logic                          read_strobe,
    output logic                          write_strobe,
    output logic                          enable_strobe
);
    import pmbt_pkg::*;

    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    pmbt_state_t          state_r;
    pmbt_state_t          state_nxt;
    logic                 op_write_r;
    logic                 op_write_nxt;
    logic [ADDR_W-1:0]    addr_r;
    logic [ADDR_W-1:0]    addr_nxt;
    logic [DATA_W-1:0]    wdata_r;
    logic [DATA_W-1:0]    wdata_nxt;
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    rdata_nxt;
    logic                 event_r;
    logic                 event_nxt;
    logic [DATA_W-1:0]    din_meta_r;
    logic [DATA_W-1:0]    din_sync_r;
    logic [1:0]           cap_r;
    logic [1:0]           cap_nxt;

    logic                 cs_one_r;
    logic                 cs_one_nxt;
    logic                 cs_two_r;
    logic                 cs_two_nxt;
    logic                 ale_lo_r;
    logic                 ale_lo_nxt;
    logic                 ale_hi_r;
    logic                 ale_hi_nxt;
    logic                 rd_r;
    logic                 rd_nxt;
    logic                 wr_r;
    logic                 wr_nxt;
    logic                 en_r;
    logic                 en_nxt;
    logic [DATA_W-1:0]    dout_r;
    logic [DATA_W-1:0]    dout_nxt;
    logic [DATA_W-1:0]    doe_r;
    logic [DATA_W-1:0]    doe_nxt;

    logic [TIMER_W-1:0]   eff_setup;
    logic [TIMER_W-1:0]   eff_strobe;
    logic [TIMER_W-1:0]   eff_hold;
    logic [TIMER_W-1:0]   alat_len;
    logic [TIMER_W-1:0]   hold_len;
    logic [TIMER_W-1:0]   load_val;
    logic                 load;
    logic                 expire;
    logic                 last;
    logic                 accept;
    logic                 cs_any;
    logic [ADDR_W-1:0]    mux_addr;
    logic                 act;
    logic                 in_strobe;

    pmbt_phase_timer #(
        .W        (TIMER_W)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (load),
        .load_val (load_val),
        .expire   (expire)
    );

    // effective phase lengths; strobe wait zero overrides both side fields
    always_comb begin
        if (strobe_wait_count == STROBE_WAIT_OFF) begin
            eff_setup  = TIMER_W'(FORCED_WAIT_CYC);
            eff_strobe = TIMER_W'(FORCED_WAIT_CYC);
            eff_hold   = TIMER_W'(FORCED_WAIT_CYC);
        end else begin
            eff_setup  = TIMER_W'(setup_wait_count) + TIMER_W'(WAIT_ADD_CYC);
            eff_strobe = TIMER_W'(strobe_wait_count) + TIMER_W'(WAIT_ADD_CYC);
            eff_hold   = TIMER_W'(hold_wait_count) + TIMER_W'(WAIT_ADD_CYC);
        end
    end

    // reads end one clock short of writes, so their hold phase may vanish
    assign alat_len = TIMER_W'(ALAT_BASE_CYC) + eff_setup;
    assign hold_len = op_write_r ? eff_hold : (eff_hold - TIMER_W'(1));

    // final clock of the whole cycle, and the busy view software polls
    assign last = ((state_r == ST_STROBE) && expire && (hold_len == '0))
                || ((state_r == ST_HOLD) && expire);
    assign busy = (state_r != ST_IDLE) && !last;
    // requests seen while busy are dropped, not queued
    assign accept = (sw_read_req || sw_write_req) && !busy
                  && ((state_r == ST_IDLE) || last);

    // sequencer: address phases, setup, strobe, hold
    always_comb begin
        state_nxt    = state_r;
        op_write_nxt = op_write_r;
        addr_nxt     = addr_r;
        wdata_nxt    = wdata_r;
        load         = 1'b0;
        load_val     = eff_setup;
        case (state_r)
            ST_ALAT_LO: begin
                if (expire) begin
                    load = 1'b1;
                    if (addr_data_mux_select == MUX_FULL8) begin
                        state_nxt = ST_ALAT_HI;
                        load_val  = alat_len;
                    end else begin
                        state_nxt = ST_SETUP;
                    end
                end
            end
            ST_ALAT_HI: begin
                if (expire) begin
                    state_nxt = ST_SETUP;
                    load      = 1'b1;
                end
            end
            ST_SETUP: begin
                if (expire) begin
                    state_nxt = ST_STROBE;
                    load      = 1'b1;
                    load_val  = eff_strobe;
                end
            end
            ST_STROBE: begin
                if (expire) begin
                    if (hold_len == '0) begin
                        state_nxt = ST_IDLE;
                    end else begin
                        state_nxt = ST_HOLD;
                        load      = 1'b1;
                        load_val  = hold_len;
                    end
                end
            end
            ST_HOLD: begin
                if (expire) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // a new request may follow straight on from the final clock
        if (accept) begin
            load         = 1'b1;
            op_write_nxt = sw_write_req;
            addr_nxt     = bus_address_register;
            if (sw_write_req) begin
                wdata_nxt = sw_write_data;
            end
            if (addr_data_mux_select == MUX_DEMUX) begin
                state_nxt = ST_SETUP;
                load_val  = eff_setup;
            end else begin
                state_nxt = ST_ALAT_LO;
                load_val  = alat_len;
            end
        end
    end

    // read capture and event flag; a new strobe outweighs a clear
    always_comb begin
        rdata_nxt = rdata_r;
        cap_nxt   = {cap_r[0], last && !op_write_r}; // pins lag two flops behind the end
        if (cap_r[1]) begin
            rdata_nxt[BYTE_W-1:0] = din_sync_r[BYTE_W-1:0];
            rdata_nxt[DATA_W-1:BYTE_W] = data_16bit ? din_sync_r[DATA_W-1:BYTE_W]
                                                    : BYTE_ZERO;
        end
        event_nxt = (load && (state_nxt == ST_STROBE))
                  || (event_r && !port_event_clear);
    end

    // pin values follow the next state, so pins change with state_r
    assign act       = (state_nxt != ST_IDLE);
    assign in_strobe = (state_nxt == ST_STROBE);
    assign cs_any    = cs_one_enable || cs_two_enable;
    assign mux_addr  = {addr_nxt[CS_TWO_BIT:CS_ONE_BIT] & {2{!cs_any}},
                        addr_nxt[CS_ONE_BIT-1:0]};

    always_comb begin
        cs_one_nxt = act && cs_one_enable && addr_nxt[CS_ONE_BIT];
        cs_two_nxt = act && cs_two_enable && addr_nxt[CS_TWO_BIT];
        // a latch pulse at the start of each address phase; in 16-bit full mux both latch strobes pulse at once
        ale_lo_nxt = load && (state_nxt == ST_ALAT_LO);
        ale_hi_nxt = load && ((state_nxt == ST_ALAT_HI)
                   || ((state_nxt == ST_ALAT_LO)
                       && (addr_data_mux_select == MUX_FULL16)));
        if (strobe_scheme == SCHEME_RD_WR) begin
            rd_nxt = in_strobe && !op_write_nxt;
            wr_nxt = in_strobe && op_write_nxt;
            en_nxt = 1'b0;
        end else begin
            rd_nxt = act && !op_write_nxt;   // direction: high reads
            wr_nxt = 1'b0;
            en_nxt = in_strobe;
        end
        dout_nxt = dout_r;
        doe_nxt  = '0;
        case (state_nxt)
            ST_ALAT_LO: begin
                if (addr_data_mux_select == MUX_FULL16) begin
                    dout_nxt = mux_addr;
                    doe_nxt  = {{BYTE_W{data_16bit}}, {BYTE_W{1'b1}}};
                end else begin
                    dout_nxt = {BYTE_ZERO, addr_nxt[BYTE_W-1:0]};
                    doe_nxt  = {BYTE_ZERO, {BYTE_W{1'b1}}};
                end
            end
            ST_ALAT_HI: begin
                dout_nxt = {BYTE_ZERO, mux_addr[ADDR_W-1:BYTE_W]};
                doe_nxt  = {BYTE_ZERO, {BYTE_W{1'b1}}};
            end
            ST_SETUP, ST_STROBE, ST_HOLD: begin
                if (op_write_nxt) begin
                    dout_nxt = wdata_nxt;
                    doe_nxt  = {{BYTE_W{data_16bit}}, {BYTE_W{1'b1}}};
                end
            end
            default: begin
                doe_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= ST_IDLE;
            op_write_r <= 1'b0;
            addr_r     <= ADDR_RST;
            wdata_r    <= BUS_DATA_RST;
            rdata_r    <= BUS_DATA_RST;
            event_r    <= 1'b0;
            din_meta_r <= '0;
            din_sync_r <= '0;
            cap_r      <= 2'h0;
            cs_one_r   <= 1'b0;
            cs_two_r   <= 1'b0;
            ale_lo_r   <= 1'b0;
            ale_hi_r   <= 1'b0;
            rd_r       <= 1'b0;
            wr_r       <= 1'b0;
            en_r       <= 1'b0;
            dout_r     <= '0;
            doe_r      <= '0;
        end else begin
            state_r    <= state_nxt;
            op_write_r <= op_write_nxt;
            addr_r     <= addr_nxt;
            wdata_r    <= wdata_nxt;
            rdata_r    <= rdata_nxt;
            event_r    <= event_nxt;
            din_meta_r <= port_data_in;
            din_sync_r <= din_meta_r;
            cap_r      <= cap_nxt;
            cs_one_r   <= cs_one_nxt;
            cs_two_r   <= cs_two_nxt;
            ale_lo_r   <= ale_lo_nxt;
            ale_hi_r   <= ale_hi_nxt;
            rd_r       <= rd_nxt;
            wr_r       <= wr_nxt;
            en_r       <= en_nxt;
            dout_r     <= dout_nxt;
            doe_r      <= doe_nxt;
        end
    end

    // software sees the value of the most recent completed read
    assign bus_data_register      = rdata_r;
    assign port_event_flag        = event_r;
    assign chip_select_one        = cs_one_r;
    assign chip_select_two        = cs_two_r;
    assign port_address_lines     = addr_r[PIN_ADDR_W-1:0];
    assign port_data_out          = dout_r;
    assign port_data_oe           = doe_r;
    assign addr_latch_low_strobe  = ale_lo_r;
    assign addr_latch_high_strobe = ale_hi_r;
    assign read_strobe            = rd_r;
    assign write_strobe           = wr_r;
    assign enable_strobe          = en_r;

endmodule

/* File: pmbt_core_chk.sv */
// pmbt_core_chk: port-level assertions on the bus cycle sequencer.
// assumes config inputs stay stable while busy is high.
`timescale 1ns/1ps
module pmbt_core_chk (
    input wire logic                        core_clk,
    input wire logic                        rst_n,
    input wire logic                        sw_read_req,
    input wire logic                        sw_write_req,
    input wire logic                        busy,
    input wire logic                        port_event_flag,
    input wire logic [1:0]                  addr_data_mux_select,
    input wire logic [3:0]                  strobe_wait_count,
    input wire logic                        strobe_scheme,
    input wire logic                        data_16bit,
    input wire logic                        cs_one_enable,
    input wire logic                        cs_two_enable,
    input wire logic [pmbt_pkg::DATA_W-1:0] port_data_out,
    input wire logic [pmbt_pkg::DATA_W-1:0] port_data_oe,
    input wire logic                        addr_latch_low_strobe,
    input wire logic                        read_strobe,
    input wire logic                        write_strobe
);
    import pmbt_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // accepted requests, qualified by no strobe wait so counts are fixed
    logic rd_go;
    logic wr_go;
    assign rd_go = !busy && sw_read_req && !sw_write_req && strobe_wait_count == 4'h0;
    assign wr_go = !busy && sw_write_req && strobe_wait_count == 4'h0;

    start_cycle_a: assert property (!busy && (sw_read_req || sw_write_req) |=> busy)
        else $error("accepted request did not raise busy");
    demux_write_a: assert property (wr_go && addr_data_mux_select == MUX_DEMUX
        |=> busy [*2] ##1 !busy) else $error("demux write length off");
    part_read_a: assert property (rd_go && addr_data_mux_select == MUX_PART
        |=> busy [*4] ##1 !busy) else $error("partial mux read length off");
    full8_write_a: assert property (wr_go && addr_data_mux_select == MUX_FULL8
        |=> busy [*8] ##1 !busy) else $error("8-bit full mux write length off");
    full16_read_a: assert property (rd_go && addr_data_mux_select == MUX_FULL16
        |=> busy [*4] ##1 !busy) else $error("16-bit full mux read length off");
    strobe_event_a: assert property (strobe_scheme && $rose(read_strobe || write_strobe)
        |-> port_event_flag) else $error("strobe did not set event flag");
    narrow_bus_a: assert property (!data_16bit |-> port_data_oe[15:8] == 8'h00)
        else $error("upper data lines driven in 8-bit width");
    split_strobe_a: assert property (strobe_scheme |-> !(read_strobe && write_strobe))
        else $error("read and write strobes together");
    top_bits_a: assert property (addr_latch_low_strobe
        && addr_data_mux_select == MUX_FULL16 && (cs_one_enable || cs_two_enable)
        |-> port_data_out[15:14] == 2'h0) else $error("top address bits not forced low");
endmodule

/* File: pmbt_periph_model.sv */
// pmbt_periph_model: external parallel device on the port pins.
// assumes active-high strobes; the bench sets the value it returns on reads.
`timescale 1ns/1ps
module pmbt_periph_model (
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        strobe_scheme,
    input  wire logic                        read_strobe,
    input  wire logic                        write_strobe,
    input  wire logic                        enable_strobe,
    input  wire logic [pmbt_pkg::DATA_W-1:0] port_data_out,
    input  wire logic [pmbt_pkg::DATA_W-1:0] port_data_oe,
    input  wire logic [pmbt_pkg::DATA_W-1:0] rd_value,
    output logic      [pmbt_pkg::DATA_W-1:0] port_data_in,
    output logic      [pmbt_pkg::DATA_W-1:0] wr_seen
);
    import pmbt_pkg::*;
    logic wr_take;
    logic wr_take_r;

    // pin level: design where it drives, the device elsewhere
    assign port_data_in = (port_data_oe & port_data_out) | (~port_data_oe & rd_value);
    // scheme 1 write is enable with direction low, scheme 2 the write strobe
    assign wr_take = strobe_scheme ? write_strobe : (enable_strobe && !read_strobe);

    // capture on the strobe's first clock; waits stretch it, data already valid
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_take_r <= 1'b0;
            wr_seen   <= 16'h0000;
        end else begin
            wr_take_r <= wr_take;
            if (wr_take && !wr_take_r) begin
                wr_seen <= port_data_out;
            end
        end
    end
endmodule

/* File: pmbt_core_test.sv */
// pmbt_core_test: self-checking bench of the parallel master bus sequencer.
// assumes a 50 MHz core_clk and the peripheral model on the data pins.
`timescale 1ns/1ps
module pmbt_core_test;
    import pmbt_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n;
    logic sw_read_req, sw_write_req, port_event_clear, strobe_scheme, data_16bit;
    logic cs_one_enable, cs_two_enable, busy, port_event_flag, chip_select_one;
    logic chip_select_two, addr_latch_low_strobe, addr_latch_high_strobe;
    logic read_strobe, write_strobe, enable_strobe;
    logic [DATA_W-1:0] sw_write_data, bus_data_register, port_data_out, port_data_oe;
    logic [DATA_W-1:0] port_data_in, rd_value, wr_seen;
    logic [ADDR_W-1:0] bus_address_register;
    logic [PIN_ADDR_W-1:0] port_address_lines;
    logic [1:0] addr_data_mux_select, setup_wait_count, hold_wait_count;
    logic [3:0] strobe_wait_count;
    int n_mismatch = 0;
    int checks = 0;
    int rd_plain[4] = '{2, 5, 8, 5};
    int rd_wait[4] = '{6, 10, 14, 10};

    pmbt_core pmbt_core_i (.core_clk, .rst_n, .sw_read_req, .sw_write_req, .sw_write_data,
        .bus_address_register, .bus_data_register, .busy, .port_event_flag,
        .port_event_clear, .addr_data_mux_select, .setup_wait_count, .strobe_wait_count,
        .hold_wait_count, .strobe_scheme, .data_16bit, .cs_one_enable, .cs_two_enable,
        .chip_select_one, .chip_select_two, .port_address_lines, .port_data_out,
        .port_data_oe, .port_data_in, .addr_latch_low_strobe, .addr_latch_high_strobe,
        .read_strobe, .write_strobe, .enable_strobe);
    pmbt_periph_model pmbt_periph_model_i (.core_clk, .rst_n, .strobe_scheme,
        .read_strobe, .write_strobe, .enable_strobe, .port_data_out, .port_data_oe,
        .rd_value, .port_data_in, .wr_seen);

    // 20 ns period
    always #10 core_clk = ~core_clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // only called while idle; scheme and width follow the mux setting
    task automatic cfg(input logic [1:0] mx, input logic [1:0] sw, input logic [3:0] mw,
                       input logic [1:0] hw);
        addr_data_mux_select = mx;
        setup_wait_count = sw;
        strobe_wait_count = mw;
        hold_wait_count = hw;
        strobe_scheme = mx[0];
        data_16bit = (mx != MUX_FULL8);
    endtask

    // one cycle; length is the busy clocks plus the final clock
    task automatic op(input logic wr, input logic [15:0] d, output int len);
        @(negedge core_clk);
        sw_write_req = wr;
        sw_read_req = !wr;
        sw_write_data = d;
        @(negedge core_clk);
        sw_write_req = 1'b0;
        sw_read_req = 1'b0;
        len = 1;
        while (busy === 1'b1 && len < 64) begin
            len++;
            @(negedge core_clk);
        end
        repeat (3) @(negedge core_clk); // read data lands after the pin synchroniser
    endtask

    task automatic rw_len(input int exp_rd);
        int len;
        logic [15:0] mask;
        mask = data_16bit ? 16'hFFFF : 16'h00FF;
        op(1'b0, 16'h0000, len);
        check("read length", len, exp_rd);
        check("read event flag", port_event_flag, 16'h0001);
        port_event_clear = 1'b1;
        @(negedge core_clk);
        port_event_clear = 1'b0;
        check("event flag cleared", port_event_flag, 16'h0000);
        op(1'b1, 16'hC35A, len);
        check("write length", len, exp_rd + 1);
        check("written data", wr_seen & mask, 16'hC35A & mask);
        check("event flag", port_event_flag, 16'h0001);
        port_event_clear = 1'b1;
        @(negedge core_clk);
        port_event_clear = 1'b0;
    endtask

    task automatic t_timing();
        for (int m = 0; m < 4; m++) begin
            cfg(m[1:0], 2'h0, 4'h0, 2'h0);
            rw_len(rd_plain[m]);
            cfg(m[1:0], 2'h1, 4'h2, 2'h1);
            rw_len(rd_wait[m]);
            cfg(m[1:0], 2'h3, 4'h0, 2'h3);
            rw_len(rd_plain[m]);
        end
    endtask

    // register shows the latest read and holds it; upper byte empty in 8-bit width
    task automatic t_read_data();
        int len;
        cfg(MUX_DEMUX, 2'h0, 4'h0, 2'h0);
        rd_value = 16'h1234;
        op(1'b0, 16'h0000, len);
        check("read data", bus_data_register, 16'h1234);
        rd_value = 16'hBEEF;
        check("held data", bus_data_register, 16'h1234);
        op(1'b0, 16'h0000, len);
        check("read data", bus_data_register, 16'hBEEF);
        cfg(MUX_FULL8, 2'h0, 4'h0, 2'h0);
        rd_value = 16'hA55A;
        op(1'b0, 16'h0000, len);
        check("narrow read", bus_data_register, 16'h005A);
    endtask

    // mid-cycle read refused, then a read in the final clock starts at once
    task automatic t_busy_rules();
        int n;
        cfg(MUX_DEMUX, 2'h1, 4'h2, 2'h1);
        @(negedge core_clk);
        sw_write_req = 1'b1;
        @(negedge core_clk);
        sw_write_req = 1'b0;
        sw_read_req = 1'b1;
        @(negedge core_clk);
        sw_read_req = 1'b0;
        n = 2;
        while (busy === 1'b1 && n < 64) begin
            n++;
            @(negedge core_clk);
        end
        check("write with refused read", n, 16'h0007);
        sw_read_req = 1'b1;
        @(negedge core_clk);
        sw_read_req = 1'b0;
        check("back to back busy", busy, 16'h0001);
        while (busy === 1'b1 && n < 128) begin
            n++;
            @(negedge core_clk);
        end
        @(negedge core_clk);
    endtask

    initial begin
        rst_n = 1'b0;
        sw_read_req = 1'b0;
        sw_write_req = 1'b0;
        sw_write_data = 16'h0000;
        port_event_clear = 1'b0;
        cs_one_enable = 1'b1;
        cs_two_enable = 1'b1;
        bus_address_register = 16'h80A5;
        rd_value = 16'h6E19;
        cfg(MUX_DEMUX, 2'h0, 4'h0, 2'h0);
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        t_timing();
        t_read_data();
        t_busy_rules();
        wrap_up();
    end

    // whole run is a few hundred clocks; this is far beyond it
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
endmodule

bind pmbt_core pmbt_core_chk pmbt_core_chk_i (.core_clk, .rst_n, .sw_read_req,
    .sw_write_req, .busy, .port_event_flag, .addr_data_mux_select, .strobe_wait_count,
    .strobe_scheme, .data_16bit, .cs_one_enable, .cs_two_enable, .port_data_out,
    .port_data_oe, .addr_latch_low_strobe, .read_strobe, .write_strobe);
